// *** hw/sfdp_power_core.sv ***
// Serial flash front end: parameter table reads, power-on state, Avalon-MM view
`timescale 1ns/1ps
module sfdp_power_core #(
    parameter int SETTLE_CYCLES = sfdp_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // Serial link pins
    input  wire logic        SEL_N,
    input  wire logic        SCLK,
    input  wire logic [3:0]  IO_IN,
    output logic      [3:0]  IO_OUT,
    output logic      [3:0]  IO_OE,
    // Avalon-MM slave
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // State seen by the array logic
    output logic             WRITE_ENABLE_LATCH,
    output logic             READY
);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    sfdp_pkg::link_in_type meta_q;
    sfdp_pkg::link_in_type pin_q;
    logic                  sclk_prev_q;
    logic                  rise;
    logic                  fall;

    // Two stages before any logic looks at a pin
    always_ff @(posedge MCLK) begin
        meta_q      <= {SEL_N, SCLK, IO_IN};
        pin_q       <= meta_q;
        sclk_prev_q <= pin_q.sclk;
    end

    assign rise = pin_q.sclk & ~sclk_prev_q & ~pin_q.sel_n;
    assign fall = ~pin_q.sclk & sclk_prev_q & ~pin_q.sel_n;

    // ********************************************************
    // Power-on state
    // ********************************************************
    sfdp_pkg::power_type pstate_q;
    logic [15:0]         settle_q;
    logic                wel_q;
    logic                cmd_done;
    logic [7:0]          opcode_q;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            settle_q <= 16'h0000;
        end else if (pstate_q == sfdp_pkg::PS_SETTLE) begin
            settle_q <= settle_q + 16'h0001;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            pstate_q <= sfdp_pkg::PS_SETTLE;
        end else begin
            unique case (pstate_q)
                sfdp_pkg::PS_SETTLE: begin
                    if (settle_q == 16'(SETTLE_CYCLES - 1)) begin
                        pstate_q <= sfdp_pkg::PS_STANDBY;
                    end
                end
                sfdp_pkg::PS_STANDBY: begin
                    if (cmd_done && opcode_q == sfdp_pkg::DPD_OPCODE) begin
                        pstate_q <= sfdp_pkg::PS_DEEP;
                    end else if (cmd_done && opcode_q == sfdp_pkg::RESET_EN_OPCODE) begin
                        pstate_q <= sfdp_pkg::PS_RST_ARM;
                    end
                end
                sfdp_pkg::PS_RST_ARM: begin
                    if (cmd_done) begin
                        pstate_q <= sfdp_pkg::PS_STANDBY;
                    end
                end
                sfdp_pkg::PS_DEEP: begin
                    if (cmd_done && opcode_q == sfdp_pkg::DPD_EXIT_OPCODE) begin
                        pstate_q <= sfdp_pkg::PS_STANDBY;
                    end
                end
                default: pstate_q <= sfdp_pkg::PS_STANDBY;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            wel_q <= 1'b0;
        end else if (cmd_done && pstate_q == sfdp_pkg::PS_STANDBY && opcode_q == sfdp_pkg::WREN_OPCODE) begin
            wel_q <= 1'b1;
        end else if (cmd_done && (opcode_q == sfdp_pkg::WRDI_OPCODE
                     || (pstate_q == sfdp_pkg::PS_RST_ARM && opcode_q == sfdp_pkg::SW_RESET_OPCODE))) begin
            wel_q <= 1'b0;
        end
    end

    // ********************************************************
    // Serial command engine
    // ********************************************************
    sfdp_pkg::lane_type lane_q;
    logic [5:0]         bitcnt_q;
    logic [7:0]         addr_q;
    logic [7:0]         rom_data;
    logic [7:0]         shift_q;
    logic [3:0]         io_out_q;
    logic [3:0]         io_oe_q;
    logic               sel_prev_q;
    logic [2:0]         step;
    logic               table_cmd;
    logic               data_phase;
    logic               byte_due;
    logic               wait_q;

    // Bits per clock follow the lane mode
    assign step      = (lane_q == sfdp_pkg::LANE_X4) ? 3'd4 : (lane_q == sfdp_pkg::LANE_X2) ? 3'd2 : 3'd1;
    assign cmd_done  = pin_q.sel_n & ~sel_prev_q & (bitcnt_q >= 6'd8);
    assign table_cmd = (opcode_q == sfdp_pkg::TABLE_OPCODE) && (pstate_q == sfdp_pkg::PS_STANDBY);
    // 8 dummy bits after 24 address bits: 8, 4 or 2 clocks by lane mode
    assign data_phase = table_cmd && (bitcnt_q >= 6'd40);
    // A lone marker at the top means the last x1 or x2 bits are already out
    assign byte_due   = (shift_q == 8'h00) || (shift_q == 8'h80);

    sfdp_rom u_rom (
        .clk    (MCLK),
        .addr   (addr_q),
        .data_q (rom_data)
    );

    // Lane mode and select edge tracking
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            lane_q     <= sfdp_pkg::LANE_X1;
            sel_prev_q <= 1'b1;
        end else begin
            sel_prev_q <= pin_q.sel_n;
            // Writes land on the completing edge only
            if (AVS_WRITE && !wait_q && AVS_ADDRESS == sfdp_pkg::REG_CONTROL) begin
                unique case (AVS_WRITEDATA[1:0])
                    2'b01:   lane_q <= sfdp_pkg::LANE_X2;
                    2'b10:   lane_q <= sfdp_pkg::LANE_X4;
                    default: lane_q <= sfdp_pkg::LANE_X1;
                endcase
            end
        end
    end

    // Opcode, address and bit counting on rising serial clock
    always_ff @(posedge MCLK) begin
        if (!RST_N || pin_q.sel_n) begin
            bitcnt_q <= 6'd0;
            opcode_q <= 8'h00;
            addr_q   <= 8'h00;
        end else if (rise) begin
            if (bitcnt_q < 6'd40) begin
                bitcnt_q <= bitcnt_q + 6'(step);
            end
            unique case (lane_q)
                sfdp_pkg::LANE_X4: begin
                    if (bitcnt_q < 6'd8) opcode_q <= {opcode_q[3:0], pin_q.io};
                    else if (bitcnt_q < 6'd32) addr_q <= {addr_q[3:0], pin_q.io};
                end
                sfdp_pkg::LANE_X2: begin
                    if (bitcnt_q < 6'd8) opcode_q <= {opcode_q[5:0], pin_q.io[1:0]};
                    else if (bitcnt_q < 6'd32) addr_q <= {addr_q[5:0], pin_q.io[1:0]};
                end
                default: begin
                    if (bitcnt_q < 6'd8) opcode_q <= {opcode_q[6:0], pin_q.io[0]};
                    else if (bitcnt_q < 6'd32) addr_q <= {addr_q[6:0], pin_q.io[0]};
                end
            endcase
        end else if (fall && data_phase && byte_due) begin
            addr_q <= addr_q + 8'h01; // Next byte once the last one is out
        end
    end

    // Data out on falling serial clock; table pointer wraps in 8 bits
    always_ff @(posedge MCLK) begin
        if (!RST_N || pin_q.sel_n) begin
            io_oe_q  <= 4'h0;
            io_out_q <= 4'h0;
            shift_q  <= 8'h00;
        end else if (fall && data_phase) begin
            unique case (lane_q)
                sfdp_pkg::LANE_X4: begin
                    io_oe_q  <= 4'hf;
                    io_out_q <= byte_due ? rom_data[7:4] : shift_q[3:0];
                    shift_q  <= byte_due ? {4'h1, rom_data[3:0]} : 8'h00;
                end
                sfdp_pkg::LANE_X2: begin
                    io_oe_q  <= 4'h3;
                    io_out_q <= {2'b00, byte_due ? rom_data[7:6] : shift_q[7:6]};
                    shift_q  <= byte_due ? {rom_data[5:0], 2'b10} : {shift_q[5:0], 2'b00};
                end
                default: begin
                    io_oe_q  <= 4'h2;
                    io_out_q <= {2'b00, byte_due ? rom_data[7] : shift_q[7], 1'b0};
                    shift_q  <= byte_due ? {rom_data[6:0], 1'b1} : {shift_q[6:0], 1'b0};
                end
            endcase
        end
    end

    // ********************************************************
    // Avalon-MM slave
    // ********************************************************
    logic [31:0] rdata_q;
    logic [7:0]  bus_byte_q;

    // One wait cycle per access, answer on the second edge
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(wait_q & (AVS_READ | AVS_WRITE));
        end
    end

    // Scratch byte at the table address, loaded from write data bits 7:0
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            bus_byte_q <= 8'h00;
        end else begin
            if (AVS_WRITE && !wait_q && AVS_ADDRESS == sfdp_pkg::REG_TABLE) begin
                bus_byte_q <= AVS_WRITEDATA[7:0];
            end
        end
    end

    // Read mux
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            rdata_q <= 32'h0;
        end else if (AVS_READ && wait_q) begin
            unique case (AVS_ADDRESS)
                sfdp_pkg::REG_STATUS:  rdata_q <= {26'h0, lane_q == sfdp_pkg::LANE_X4, lane_q == sfdp_pkg::LANE_X2,
                                                  pstate_q == sfdp_pkg::PS_DEEP, wel_q,
                                                  pstate_q != sfdp_pkg::PS_SETTLE, 1'b0};
                sfdp_pkg::REG_CONTROL: rdata_q <= {30'h0, lane_q == sfdp_pkg::LANE_X4, lane_q == sfdp_pkg::LANE_X2};
                sfdp_pkg::REG_TABLE:   rdata_q <= {24'h0, bus_byte_q};
                default:               rdata_q <= sfdp_pkg::BAD_READ;
            endcase
        end
    end

    // Registered outputs
    assign IO_OUT             = io_out_q;
    assign IO_OE              = io_oe_q;
    assign AVS_READDATA       = rdata_q;
    assign AVS_WAITREQUEST    = wait_q;
    assign WRITE_ENABLE_LATCH = wel_q;
    assign READY              = pstate_q[1];

    // ********************************************************
    // Checks
    // ********************************************************
    sequence s_powered;
        pstate_q == sfdp_pkg::PS_SETTLE ##1 pstate_q == sfdp_pkg::PS_STANDBY;
    endsequence

    property p_standby_after_settle;
        @(posedge MCLK) disable iff (!RST_N) s_powered |-> !wel_q && READY;
    endproperty
    a_standby_after_settle: assert property (p_standby_after_settle) else $error("Settle did not end in standby");

    property p_wel_reset;
        @(posedge MCLK) $rose(RST_N) |-> !wel_q;
    endproperty
    a_wel_reset: assert property (p_wel_reset) else $error("Latch set after reset");

    property p_no_read_settling;
        @(posedge MCLK) disable iff (!RST_N) pstate_q == sfdp_pkg::PS_SETTLE |-> IO_OE == 4'h0;
    endproperty
    a_no_read_settling: assert property (p_no_read_settling) else $error("Drove data before settle");

    property p_lane_legal;
        @(posedge MCLK) disable iff (!RST_N) $onehot(lane_q);
    endproperty
    a_lane_legal: assert property (p_lane_legal) else $error("Illegal lane mode");

    property p_dummy_quiet;
        @(posedge MCLK) disable iff (!RST_N) bitcnt_q < 6'd40 |-> io_oe_q == 4'h0;
    endproperty
    a_dummy_quiet: assert property (p_dummy_quiet) else $error("Drove during address or dummy");

    property p_cap_word;
        @(posedge MCLK) addr_q == 8'h64 ##1 addr_q == 8'h64 |-> rom_data == 8'h9e;
    endproperty
    a_cap_word: assert property (p_cap_word) else $error("Capability byte wrong");

    property p_fill;
        @(posedge MCLK) addr_q >= 8'h6a ##1 addr_q >= 8'h6a |-> rom_data == sfdp_pkg::FILL_BYTE;
    endproperty
    a_fill: assert property (p_fill) else $error("Unused byte not blank");

    property p_lock_word;
        @(posedge MCLK) addr_q == 8'h69 ##1 addr_q == 8'h69 |-> rom_data == 8'hc8;
    endproperty
    a_lock_word: assert property (p_lock_word) else $error("Lock byte wrong");

endmodule // sfdp_power_core

// *** hw/sfdp_pkg.sv ***
// Shared constants and types for the parameter-table and power-on block
// Function
// - Capability word reports reset pin absent; hold, deep power-down, software reset present.
// - Suspend, resume and wrap read unsupported; wrap opcode and length bytes read FFh.
// - Block locking supported, volatile lock bits, lock opcode 36h advertised.
// - Volatile lock bits default to protected, shown as bit 10 zero.
// - One-time-programmable area supported; read lock and permanent lock unsupported.
// - All unused table bytes, 6Ch to 6Fh included, read FFh.
// - Table read only in lane modes 1-1-1, 2-2-2 or 4-4-4.
// - Wait states are dummy clocks after address or mode bits, before data.
// - Power-up enters standby, never deep power-down.
// - Power-up clears the write enable latch; writes locked until write-enable.
// - Commands only after the settle delay; device then accepts reads.
package sfdp_pkg;

    // ********************************************************
    // Table layout
    // ********************************************************
    localparam logic [7:0] TABLE_BASE      = 8'h60;
    localparam logic [7:0] TABLE_LAST      = 8'h6f;
    localparam logic [7:0] FILL_BYTE       = 8'hff;
    localparam logic [7:0] SUPPLY_MAX_LO   = 8'h00;
    localparam logic [7:0] SUPPLY_MAX_HI   = 8'h36;
    localparam logic [7:0] SUPPLY_MIN_LO   = 8'h00;
    localparam logic [7:0] SUPPLY_MIN_HI   = 8'h27;
    localparam logic [7:0] RESET_EN_OPCODE = 8'h66;
    localparam logic [7:0] SW_RESET_OPCODE = 8'h99;
    localparam logic [7:0] LOCK_OPCODE     = 8'h36;
    localparam logic [7:0] WREN_OPCODE     = 8'h06;
    localparam logic [7:0] WRDI_OPCODE     = 8'h04;
    localparam logic [7:0] DPD_OPCODE      = 8'hb9;
    localparam logic [7:0] DPD_EXIT_OPCODE = 8'hab;
    localparam logic [7:0] TABLE_OPCODE    = 8'h5a;

    // Capability word bit positions at 64h-65h
    localparam int CAP_RESET_PIN  = 0;
    localparam int CAP_HOLD_PIN   = 1;
    localparam int CAP_DPD        = 2;
    localparam int CAP_SW_RESET   = 3;
    localparam int CAP_OPC_LSB    = 4;
    localparam int CAP_PGM_SUSP   = 12;
    localparam int CAP_ERS_SUSP   = 13;
    localparam int CAP_UNUSED14   = 14;
    localparam int CAP_WRAP       = 15;
    // Lock word bit positions at 68h-69h
    localparam int LCK_SUPPORT    = 0;
    localparam int LCK_NONVOL     = 1;
    localparam int LCK_OPC_LSB    = 2;
    localparam int LCK_DEFAULT    = 10;
    localparam int LCK_OTP        = 11;
    localparam int LCK_READ_LOCK  = 12;
    localparam int LCK_PERM_LOCK  = 13;

    // ********************************************************
    // Timing and register map
    // ********************************************************
    localparam int SETTLE_US      = 800;
    localparam int CLK_MHZ        = 10;
    localparam int SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;

    localparam logic [3:0] REG_STATUS  = 4'h0;
    localparam logic [3:0] REG_CONTROL = 4'h1;
    localparam logic [3:0] REG_TABLE   = 4'h2;
    localparam logic [31:0] BAD_READ   = 32'hdeadbeef;

    // Link lane mode
    typedef enum logic [2:0] {
        LANE_X1 = 3'b001,
        LANE_X2 = 3'b010,
        LANE_X4 = 3'b100
    } lane_type;

    // Power and command state
    typedef enum logic [3:0] {
        PS_SETTLE  = 4'b0001,
        PS_STANDBY = 4'b0010,
        PS_DEEP    = 4'b0100,
        PS_RST_ARM = 4'b1000
    } power_type;

    // Serial pins sampled into the core clock
    typedef struct packed {
        logic       sel_n;
        logic       sclk;
        logic [3:0] io;
    } link_in_type;

endpackage

// *** hw/sfdp_rom.sv ***
// Registered read of the parameter table bytes 60h-6Fh
`timescale 1ns/1ps
module sfdp_rom (
    // Clock
    input  wire logic       clk,
    // Read port
    input  wire logic [7:0] addr,
    output logic      [7:0] data_q
);

    logic [7:0] data_d;

    // Byte lookup; every byte outside the table reads blank
    always_comb begin
        data_d = sfdp_pkg::FILL_BYTE;
        unique case (addr)
            8'h60: data_d = sfdp_pkg::SUPPLY_MAX_LO;
            8'h61: data_d = sfdp_pkg::SUPPLY_MAX_HI;
            8'h62: data_d = sfdp_pkg::SUPPLY_MIN_LO;
            8'h63: data_d = sfdp_pkg::SUPPLY_MIN_HI;
            8'h64: data_d = {sfdp_pkg::SW_RESET_OPCODE[3:0], 4'b1110};
            8'h65: data_d = {4'b0100, sfdp_pkg::SW_RESET_OPCODE[7:4]};
            8'h66: data_d = sfdp_pkg::FILL_BYTE;
            8'h67: data_d = sfdp_pkg::FILL_BYTE;
            8'h68: data_d = {sfdp_pkg::LOCK_OPCODE[5:0], 2'b01};
            8'h69: data_d = {2'b11, 1'b0, 1'b0, 1'b1, 1'b0, sfdp_pkg::LOCK_OPCODE[7:6]};
            default: data_d = sfdp_pkg::FILL_BYTE;
        endcase
    end

    // Registered output
    always_ff @(posedge clk) begin
        data_q <= data_d;
    end

endmodule // sfdp_rom

// *** tb/sfdp_host_model.sv ***
// Host controller model that drives the serial link and collects read bytes
`timescale 1ns/1ps
module sfdp_host_model (
    // Clock
    input  wire logic       clk,
    // Link pins
    output logic            sel_n,
    output logic            sclk,
    output logic      [3:0] io,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    logic [7:0] rx [16];
    logic [3:0] oe_or;
    logic       oe_ok;

    // Idle: deselected, clock parked low, hold and protect pins high
    // deselected at power-up
    initial begin
        sel_n = 1'b1;
        sclk  = 1'b0;
        io    = 4'hd;
    end

    // One link phase is four core clocks, so the link period is 800 ns
    task automatic half();
        repeat (4) @(posedge clk);
    endtask

    // One frame: opcode alone, or a 40-bit table header then nrd bytes
    task automatic xfer(input logic [7:0] op, input logic [7:0] a, input int nrd, input int w);
        logic [39:0] sh;
        logic [3:0]  mask;
        logic [7:0]  b;
        sh    = {op, 16'h0000, a, 8'h00};
        mask  = (w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hf;
        oe_or = 4'h0;
        oe_ok = 1'b1;
        b     = 8'h00;
        sel_n <= 1'b0;
        // address then dummy clocks, no mode bits
        for (int i = 0; i < ((nrd == 0) ? 8 : 40); i += w) begin
            io <= (w == 4) ? sh[39:36] : (w == 2) ? {2'b11, sh[39:38]} : {2'b11, ~io[1], sh[39]};
            sh = sh << w;
            half();
            sclk <= 1'b1;
            half();
            sclk <= 1'b0;
        end
        // Released lanes toggle so a stale level never reads as data
        for (int k = 0; k < nrd; k++) begin
            for (int j = 0; j < 8; j += w) begin
                io <= (w == 4) ? ~io : {2'b11, ~io[1:0]};
                half();
                sclk <= 1'b1;
                b = (w == 4) ? {b[3:0], io_out} : (w == 2) ? {b[5:0], io_out[1:0]} : {b[6:0], io_out[1]};
                oe_or = oe_or | io_oe;
                if (io_oe !== mask) oe_ok = 1'b0;
                half();
                sclk <= 1'b0;
            end
            rx[k] = b;
        end
        half();
        sel_n <= 1'b1;
        io    <= {2'b11, ~io[1:0]};
        half();
        half();
    endtask
endmodule // sfdp_host_model

// *** tb/sfdp_power_core_tb.sv ***
// Self-checking bench for the parameter table and power-on block
`timescale 1ns/1ps
module sfdp_power_core_tb;
    localparam int SETTLE = 200;
    logic        mclk          = 1'b0;
    logic        rst_n         = 1'b0;
    logic [3:0]  avs_address   = 4'h0;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic        sel_n;
    logic        sclk;
    logic [3:0]  io_in;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        write_enable_latch;
    logic        ready;
    logic [31:0] rd;
    int          err_count     = 0;
    int          check_count   = 0;

    // Core clock, 100 ns period
    always #50 mclk = ~mclk;

    sfdp_power_core #(.SETTLE_CYCLES(SETTLE)) DUT (
        .MCLK(mclk), .RST_N(rst_n), .SEL_N(sel_n), .SCLK(sclk), .IO_IN(io_in),
        .IO_OUT(io_out), .IO_OE(io_oe), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .WRITE_ENABLE_LATCH(write_enable_latch), .READY(ready));

    sfdp_host_model host (.clk(mclk), .sel_n(sel_n), .sclk(sclk), .io(io_in), .io_out(io_out), .io_oe(io_oe));

    // ********************************
    // Shared tasks
    // ********************************
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bus cycle held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= ~wr;
        avs_write     <= wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
        if (n >= 50) chk("bus answer", 32'h1, 32'h0);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
    endtask

    // Bounded wait so the link stays quiet until the device has settled
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 1000) begin
            @(posedge mclk);
            n++;
        end
    endtask

    function automatic logic [7:0] exp_byte(input int a);
        logic [15:0] cap;
        logic [15:0] lck;
        cap = {1'b0, 1'b1, 2'b00, sfdp_pkg::SW_RESET_OPCODE, 4'b1110};
        lck = {2'b11, 2'b00, 1'b1, 1'b0, sfdp_pkg::LOCK_OPCODE, 2'b01};
        case (a)
            0: return 8'h00;
            1: return 8'h36;
            2: return 8'h00;
            3: return 8'h27;
            4: return cap[7:0];
            5: return cap[15:8];
            8: return lck[7:0];
            9: return lck[15:8];
            default: return 8'hff;
        endcase
    endfunction

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_power_on();
        realtime t0;
        int      n;
        do_reset();
        t0 = $realtime;
        host.xfer(sfdp_pkg::WREN_OPCODE, 8'h00, 0, 1);
        chk("early latch", 32'h0, {31'h0, write_enable_latch});
        av(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
        chk("status settling", 32'h0, rd);
        wait_ready();
        n = int'(($realtime - t0) / 100.0);
        chk("settle cycles", 32'h1, {31'h0, (n >= SETTLE && n <= SETTLE + 2)});
        av(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
        chk("status standby", 32'h2, rd);
    endtask

    task automatic t_table(input int w);
        av(1'b1, sfdp_pkg::REG_CONTROL, (w == 4) ? 32'h2 : (w == 2) ? 32'h1 : 32'h0);
        av(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
        chk("lane status", (w == 4) ? 32'h22 : (w == 2) ? 32'h12 : 32'h02, rd);
        host.xfer(sfdp_pkg::TABLE_OPCODE, sfdp_pkg::TABLE_BASE, 16, w);
        for (int k = 0; k < 16; k++)
            chk($sformatf("table byte %0d", k), {24'h0, exp_byte(k)}, {24'h0, host.rx[k]});
        chk("lane enables", 32'h1, {31'h0, host.oe_ok});
        chk("released enables", 32'h0, {28'h0, io_oe});
    endtask

    task automatic t_latch();
        host.xfer(sfdp_pkg::WREN_OPCODE, 8'h00, 0, 1);
        av(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
        chk("status latch set", 32'h6, rd);
        host.xfer(sfdp_pkg::WRDI_OPCODE, 8'h00, 0, 1);
        chk("latch cleared", 32'h0, {31'h0, write_enable_latch});
        host.xfer(sfdp_pkg::WREN_OPCODE, 8'h00, 0, 1);
        host.xfer(sfdp_pkg::SW_RESET_OPCODE, 8'h00, 0, 1);
        chk("lone reset ignored", 32'h1, {31'h0, write_enable_latch});
        host.xfer(sfdp_pkg::RESET_EN_OPCODE, 8'h00, 0, 1);
        host.xfer(sfdp_pkg::SW_RESET_OPCODE, 8'h00, 0, 1);
        wait_ready();
        chk("reset pair clears", 32'h0, {31'h0, write_enable_latch});
    endtask

    task automatic t_deep();
        host.xfer(sfdp_pkg::DPD_OPCODE, 8'h00, 0, 1);
        av(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
        chk("deep flag", 32'h1, {31'h0, rd[3]});
        host.xfer(sfdp_pkg::TABLE_OPCODE, sfdp_pkg::TABLE_BASE, 2, 1);
        chk("silent in deep", 32'h0, {28'h0, host.oe_or});
        host.xfer(sfdp_pkg::DPD_EXIT_OPCODE, 8'h00, 0, 1);
        wait_ready();
        av(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
        chk("deep exit", 32'h2, rd);
    endtask

    task automatic t_bus();
        av(1'b0, 4'hf, 32'h0);
        chk("unmapped read", sfdp_pkg::BAD_READ, rd);
        av(1'b1, 4'hf, 32'hffffffff);
        av(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
        chk("unmapped write", 32'h2, rd);
        av(1'b1, sfdp_pkg::REG_TABLE, 32'h123456a5);
        av(1'b0, sfdp_pkg::REG_TABLE, 32'h0);
        chk("scratch byte", 32'ha5, rd);
    endtask

    // Mid-run reset acts as a second power-up
    task automatic t_rst_again();
        host.xfer(sfdp_pkg::WREN_OPCODE, 8'h00, 0, 1);
        av(1'b1, sfdp_pkg::REG_CONTROL, 32'h2);
        do_reset();
        @(posedge mclk);
        av(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
        chk("status after reset", 32'h0, rd);
        wait_ready();
        chk("ready again", 32'h1, {31'h0, ready});
    endtask

    // Main sequence
    initial begin
        t_power_on();
        for (int w = 4; w > 0; w = w / 2)
            t_table(w);
        t_latch();
        t_deep();
        t_bus();
        t_rst_again();
        final_report();
    end

    // Watchdog: the full run needs well under 10000 cycles
    initial begin
        repeat (30000) @(posedge mclk);
        err_count++;
        final_report();
    end
endmodule // sfdp_power_core_tb
